// [logic/fpl_defs.vh]
// Constants for the flash protection logic
// What this block does
// - Two 64 kB arrays; first has reserved top
// - User sees only lower 62 kB of array 0
// - Hidden 2 kB firmware page is never accessed
// - Array 1 fully usable, nothing reserved
// - Erase whole pages; program erased locations only
// - Boot pin low at reset selects serial download
// - Bit 31 blocks debug and parallel reads
// - Other 31 bits guard four-page groups
// - Write protection applies to every access path
// - Array 1: all 32 bits guard groups
// - Volatile protection immediate, unprotected after reset
// - Persistent value applies after save and reset
// - Persistent register changes need matching key unless key is erased
// - Mass erase sets key 0xFFFF, erases code
// - Key 0xDEADDEAD locks protection until mass erase
// - Cleared bit means group protected
// - Status: done, fail, busy, pending; read clears
`ifndef FPL_DEFS_VH
`define FPL_DEFS_VH

// Register offsets inside one array's window
`define FPL_OFS_STA 7'h00
`define FPL_OFS_MOD 7'h04
`define FPL_OFS_CON 7'h08
`define FPL_OFS_DAT 7'h0c
`define FPL_OFS_ADR 7'h10
`define FPL_OFS_PRO 7'h1c
`define FPL_OFS_HID 7'h20
`define FPL_BANK_BIT 7

// Reset values and key constants
`define FPL_MOD_RST 8'h80
`define FPL_PROT_NONE 32'hffffffff
`define FPL_KEY_ERASED 32'h0000ffff
`define FPL_KEY_PERM 32'hdeaddead

// Mode bits
`define FPL_MOD_EKEY 3
`define FPL_MOD_IRQEN 4
`define FPL_MOD_KEYOFF 5
`define FPL_MOD_KEYON 6

// Status bits
`define FPL_STA_DONE 0
`define FPL_STA_FAIL 1
`define FPL_STA_BUSY 2
`define FPL_STA_IRQ 3

// Commands
`define FPL_CMD_PROG 8'h02
`define FPL_CMD_PERASE 8'h05
`define FPL_CMD_MERASE 8'h06
`define FPL_CMD_SAVEKEY 8'h0c
`define FPL_MER_DAT 16'h3cff
`define FPL_MER_ADR 16'hffc3

// Address layout
`define FPL_GRP_MSB 15
`define FPL_GRP_LSB 11
`define FPL_PAGE_LSB 9
`define FPL_HIDDEN_GRP 5'h1f
`define FPL_RDPROT_BIT 31

// Flash engine operations
`define FPL_OP_NONE 2'h0
`define FPL_OP_PROG 2'h1
`define FPL_OP_PERASE 2'h2
`define FPL_OP_MERASE 2'h3

`endif

// [logic/fpl_nv_store.v]
// Nonvolatile key and saved protection image per array
`timescale 1ns/10ps
`default_nettype none
`include "fpl_defs.vh"

module fpl_nv_store #(
   parameter BANKS = 2
) (
   // Clock and power-up
   input wire clk_sys,
   input wire ce,
   input wire por,
   // Updates
   input wire [BANKS-1:0] save_en,
   input wire [32*BANKS-1:0] save_key,
   input wire [32*BANKS-1:0] save_pro,
   input wire [BANKS-1:0] erase_en,
   // Stored image
   output reg [32*BANKS-1:0] nv_key,
   output reg [32*BANKS-1:0] nv_pro
);

   genvar b;
   generate
      for (b = 0; b < BANKS; b = b + 1) begin : g_bank
         // Power-up and a completed mass erase clear the image; system reset keeps it
         always @(posedge clk_sys) begin
            if (ce && por) begin
               nv_key[b*32 +: 32] <= `FPL_KEY_ERASED;
               nv_pro[b*32 +: 32] <= `FPL_PROT_NONE;
            end else if (ce) begin
               if (erase_en[b]) begin
                  nv_key[b*32 +: 32] <= `FPL_KEY_ERASED;
                  nv_pro[b*32 +: 32] <= `FPL_PROT_NONE;
               end else if (save_en[b]) begin
                  nv_key[b*32 +: 32] <= save_key[b*32 +: 32];
                  nv_pro[b*32 +: 32] <= save_pro[b*32 +: 32];
               end
            end
         end
      end
   endgenerate

endmodule // fpl_nv_store
`default_nettype wire

// [logic/fpl_top.v]
// Flash protection and command gate for two arrays
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "fpl_defs.vh"

module fpl_top #(
   parameter BANKS = 2
) (
   // Clock, reset, enable
   input wire clk_sys,
   input wire rst,
   input wire ce,
   input wire por,
   // Register port
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // Boot select pin
   input wire boot_select_pin_n,
   output reg serial_download,
   // Flash array engine
   output wire [BANKS-1:0] fl_req,
   output wire [2*BANKS-1:0] fl_op,
   output wire [16*BANKS-1:0] fl_addr,
   output wire [8*BANKS-1:0] fl_data,
   input wire [BANKS-1:0] fl_done,
   input wire [BANKS-1:0] fl_fail,
   // Debug, parallel and download path
   input wire ext_req,
   input wire ext_write,
   input wire ext_bank,
   input wire [15:0] ext_addr,
   output reg ext_grant,
   output reg ext_deny
);

   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;

   wire [32*BANKS-1:0] nv_key;
   wire [32*BANKS-1:0] nv_pro;
   wire [32*BANKS-1:0] eff_prot;
   wire [32*BANKS-1:0] bank_rd;
   wire [32*BANKS-1:0] sav_key;
   wire [32*BANKS-1:0] sav_pro;
   wire [BANKS-1:0] sav_en;
   wire [BANKS-1:0] ers_en;

   wire [6:0] ofs = reg_addr[6:0];

   genvar b;
   generate
      for (b = 0; b < BANKS; b = b + 1) begin : g_bank
         reg [7:0] mod_r;
         reg [7:0] cmd_r;
         reg [15:0] dat_r;
         reg [15:0] adr_r;
         reg [31:0] pro_r;
         reg [31:0] hid_r;
         reg [31:0] appl_r;
         reg done_r;
         reg fail_r;
         reg irq_r;
         reg res_v_r;
         reg res_f_r;
         reg [1:0] st_r;
         reg req_r;
         reg [1:0] op_r;
         reg [15:0] fadr_r;
         reg [7:0] fdat_r;
         reg save_r;
         reg erase_r;
         reg [31:0] rd_w;

         // Window select: address bit 7 picks the array
         wire sel = (reg_addr[`FPL_BANK_BIT] == b);
         wire wr_sta = reg_wr & sel & (ofs == `FPL_OFS_STA);
         wire wr_mod = reg_wr & sel & (ofs == `FPL_OFS_MOD);
         wire wr_con = reg_wr & sel & (ofs == `FPL_OFS_CON);
         wire wr_dat = reg_wr & sel & (ofs == `FPL_OFS_DAT);
         wire wr_adr = reg_wr & sel & (ofs == `FPL_OFS_ADR);
         wire wr_pro = reg_wr & sel & (ofs == `FPL_OFS_PRO);
         wire wr_hid = reg_wr & sel & (ofs == `FPL_OFS_HID);
         wire rd_sta = reg_rd & sel & (ofs == `FPL_OFS_STA);

         // Active mask: low bit means protected
         wire [31:0] eff = appl_r & hid_r;
         wire [4:0] grp = adr_r[`FPL_GRP_MSB:`FPL_GRP_LSB];
         // Top group of array 0 holds hidden firmware
         wire hidden = (b == 0) && (grp == `FPL_HIDDEN_GRP);
         wire wprot = hidden | ~eff[grp];
         wire [31:0] key_in = {adr_r, dat_r};
         wire [31:0] key_nv = nv_key[b*32 +: 32];
         wire key_mode = mod_r[`FPL_MOD_KEYON] & ~mod_r[`FPL_MOD_KEYOFF];
         wire key_free = (key_nv == `FPL_KEY_ERASED);
         wire key_perm = (key_nv == `FPL_KEY_PERM);
         wire key_ok = key_mode & ~key_perm & (key_free | (key_in == key_nv));
         wire mer_ok = mod_r[`FPL_MOD_EKEY] & (dat_r == `FPL_MER_DAT)
            & (adr_r == `FPL_MER_ADR);
         wire go = wr_con & (st_r == ST_IDLE);
         wire [7:0] cmd_w = reg_wdata[7:0];

         assign eff_prot[b*32 +: 32] = eff;
         assign fl_req[b] = req_r;
         assign fl_op[b*2 +: 2] = op_r;
         assign fl_addr[b*16 +: 16] = fadr_r;
         assign fl_data[b*8 +: 8] = fdat_r;
         assign sav_en[b] = save_r;
         assign ers_en[b] = erase_r;
         assign sav_key[b*32 +: 32] = key_in;
         assign sav_pro[b*32 +: 32] = pro_r;

         always @* begin
            rd_w = 32'h00000000;
            case (ofs)
               `FPL_OFS_STA: begin
                  rd_w[`FPL_STA_DONE] = done_r;
                  rd_w[`FPL_STA_FAIL] = fail_r;
                  rd_w[`FPL_STA_BUSY] = (st_r != ST_IDLE);
                  rd_w[`FPL_STA_IRQ] = irq_r;
               end
               `FPL_OFS_MOD: rd_w[7:0] = mod_r;
               `FPL_OFS_CON: rd_w[7:0] = cmd_r;
               `FPL_OFS_DAT: rd_w[15:0] = dat_r;
               `FPL_OFS_ADR: rd_w[15:0] = adr_r;
               `FPL_OFS_PRO: rd_w = pro_r;
               `FPL_OFS_HID: rd_w = hid_r;
               default: rd_w = 32'h00000000;
            endcase
         end
         assign bank_rd[b*32 +: 32] = rd_w;

         // Software registers
         always @(posedge clk_sys) begin
            if (ce && rst) begin
               mod_r <= `FPL_MOD_RST;
               dat_r <= 16'h0000;
               adr_r <= 16'h0000;
               pro_r <= 32'h00000000;
               hid_r <= `FPL_PROT_NONE;
               appl_r <= nv_pro[b*32 +: 32];
            end else if (ce) begin
               if (wr_mod) begin
                  mod_r <= reg_wdata[7:0];
               end
               if (wr_dat) begin
                  dat_r <= reg_wdata[15:0];
               end
               if (wr_adr) begin
                  adr_r <= reg_wdata[15:0];
               end
               if (wr_pro) begin
                  pro_r <= reg_wdata;
               end
               if (wr_hid) begin
                  hid_r <= reg_wdata;
               end
            end
         end

         // Status flags: a new result wins over the read clear
         always @(posedge clk_sys) begin
            if (ce && rst) begin
               done_r <= 1'b0;
               fail_r <= 1'b0;
               irq_r <= 1'b0;
            end else if (ce) begin
               if (res_v_r) begin
                  done_r <= ~res_f_r;
                  fail_r <= res_f_r;
                  irq_r <= mod_r[`FPL_MOD_IRQEN];
               end else if (rd_sta) begin
                  done_r <= 1'b0;
                  fail_r <= 1'b0;
                  irq_r <= 1'b0;
               end else if (wr_sta) begin
                  done_r <= reg_wdata[`FPL_STA_DONE];
                  fail_r <= reg_wdata[`FPL_STA_FAIL];
                  irq_r <= reg_wdata[`FPL_STA_IRQ];
               end
            end
         end

         // Command engine
         always @(posedge clk_sys) begin
            if (ce && rst) begin
               cmd_r <= 8'h00;
               st_r <= ST_IDLE;
               req_r <= 1'b0;
               op_r <= `FPL_OP_NONE;
               fadr_r <= 16'h0000;
               fdat_r <= 8'h00;
               res_v_r <= 1'b0;
               res_f_r <= 1'b0;
               save_r <= 1'b0;
               erase_r <= 1'b0;
            end else if (ce) begin
               req_r <= 1'b0;
               res_v_r <= 1'b0;
               save_r <= 1'b0;
               erase_r <= 1'b0;
               case (st_r)
                  ST_IDLE: begin
                     if (go) begin
                        cmd_r <= cmd_w;
                        case (cmd_w)
                           `FPL_CMD_PROG: begin
                              if (wprot) begin
                                 res_v_r <= 1'b1;
                                 res_f_r <= 1'b1;
                              end else begin
                                 req_r <= 1'b1;
                                 op_r <= `FPL_OP_PROG;
                                 fadr_r <= adr_r;
                                 fdat_r <= dat_r[7:0];
                                 st_r <= ST_WAIT;
                              end
                           end
                           `FPL_CMD_PERASE: begin
                              if (wprot) begin
                                 res_v_r <= 1'b1;
                                 res_f_r <= 1'b1;
                              end else begin
                                 req_r <= 1'b1;
                                 op_r <= `FPL_OP_PERASE;
                                 fadr_r <= {adr_r[15:`FPL_PAGE_LSB],
                                    {`FPL_PAGE_LSB{1'b0}}};
                                 st_r <= ST_WAIT;
                              end
                           end
                           `FPL_CMD_MERASE: begin
                              if (mer_ok) begin
                                 req_r <= 1'b1;
                                 op_r <= `FPL_OP_MERASE;
                                 fadr_r <= 16'h0000;
                                 st_r <= ST_WAIT;
                              end else begin
                                 res_v_r <= 1'b1;
                                 res_f_r <= 1'b1;
                              end
                           end
                           `FPL_CMD_SAVEKEY: begin
                              save_r <= key_ok;
                              res_v_r <= 1'b1;
                              res_f_r <= ~key_ok;
                           end
                           default: begin
                              res_v_r <= 1'b1;
                              res_f_r <= 1'b1;
                           end
                        endcase
                     end
                  end
                  ST_WAIT: begin
                     if (fl_done[b]) begin
                        res_v_r <= 1'b1;
                        // Engine refuses programming of unerased cells
                        res_f_r <= fl_fail[b];
                        erase_r <= (op_r == `FPL_OP_MERASE) & ~fl_fail[b];
                        st_r <= ST_IDLE;
                     end
                  end
                  default: begin
                     st_r <= ST_IDLE;
                  end
               endcase
            end
         end
      end
   endgenerate

   fpl_nv_store #(
      .BANKS(BANKS)
   ) u_nv (
      .clk_sys(clk_sys),
      .ce(ce),
      .por(por),
      .save_en(sav_en),
      .save_key(sav_key),
      .save_pro(sav_pro),
      .erase_en(ers_en),
      .nv_key(nv_key),
      .nv_pro(nv_pro)
   );

   // Read data, one cycle after the strobe
   always @(posedge clk_sys) begin
      if (ce && rst) begin
         reg_rdata <= 32'h00000000;
      end else if (ce) begin
         if (reg_rd) begin
            if (reg_addr[`FPL_BANK_BIT] && BANKS > 1) begin
               reg_rdata <= bank_rd[32 +: 32];
            end else begin
               reg_rdata <= bank_rd[31:0];
            end
         end else begin
            reg_rdata <= 32'h00000000;
         end
      end
   end

   // External path check
   wire [4:0] ext_grp = ext_addr[`FPL_GRP_MSB:`FPL_GRP_LSB];
   wire [31:0] ext_eff = ext_bank ? eff_prot[32*BANKS-1 -: 32] : eff_prot[31:0];
   wire ext_hidden = ~ext_bank & (ext_grp == `FPL_HIDDEN_GRP);
   wire ext_rdprot = ~eff_prot[`FPL_RDPROT_BIT];
   wire ext_bad = ext_hidden | (ext_write ? ~ext_eff[ext_grp] : ext_rdprot);

   always @(posedge clk_sys) begin
      if (ce && rst) begin
         ext_grant <= 1'b0;
         ext_deny <= 1'b0;
      end else if (ce) begin
         ext_grant <= ext_req & ~ext_bad;
         ext_deny <= ext_req & ext_bad;
      end
   end

   // Boot pin: two flops, caught once after reset release
   reg boot_s1_r;
   reg boot_s2_r;
   reg boot_cap_r;

   always @(posedge clk_sys) begin
      if (ce) begin
         boot_s1_r <= boot_select_pin_n;
         boot_s2_r <= boot_s1_r;
      end
   end

   always @(posedge clk_sys) begin
      if (ce && rst) begin
         boot_cap_r <= 1'b1;
         serial_download <= 1'b0;
      end else if (ce && boot_cap_r) begin
         boot_cap_r <= 1'b0;
         serial_download <= ~boot_s2_r;
      end
   end

endmodule // fpl_top
`default_nettype wire

// [tb/fpl_top_chk.sv]
// Assertion checker for the flash protection top
`timescale 1ns/10ps
`default_nettype none

module fpl_top_chk #(
   parameter BANKS = 2
) (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic por,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // Boot select
   input wire logic boot_select_pin_n,
   input wire logic serial_download,
   // Flash engine
   input wire logic [BANKS-1:0] fl_req,
   input wire logic [2*BANKS-1:0] fl_op,
   input wire logic [16*BANKS-1:0] fl_addr,
   input wire logic [8*BANKS-1:0] fl_data,
   input wire logic [BANKS-1:0] fl_done,
   input wire logic [BANKS-1:0] fl_fail,
   // External path
   input wire logic ext_req,
   input wire logic ext_write,
   input wire logic ext_bank,
   input wire logic [15:0] ext_addr,
   input wire logic ext_grant,
   input wire logic ext_deny
);
   logic [15:0] adr0_r;
   logic con0_r;

   // Mirror of array 0 address and command writes
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         adr0_r <= 16'h0000;
         con0_r <= 1'b0;
      end else begin
         con0_r <= ce && reg_wr && reg_addr == 8'h08;
         if (ce && reg_wr && reg_addr == 8'h10) begin
            adr0_r <= reg_wdata[15:0];
         end
      end
   end

   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   a_rdata_quiet: assert property ((ce && !reg_rd) |=> reg_rdata == 32'h0)
      else $error("read data not zero outside a read answer");
   a_ext_answer: assert property ((ce && ext_req) |=> ext_grant != ext_deny)
      else $error("external request not answered exactly once");
   a_ext_quiet: assert property ((ce && !ext_req) |=> !(ext_grant || ext_deny))
      else $error("external answer without request");
   a_hidden_ext: assert property ((ce && ext_req && !ext_bank && ext_addr[15:11] == 5'h1f)
      |=> ext_deny)
      else $error("hidden page reachable from external path");
   a_hidden_cmd: assert property ((ce && reg_wr && reg_addr == 8'h08 &&
      reg_wdata[7:0] != 8'h06 && adr0_r[15:11] == 5'h1f) |=> !fl_req[0])
      else $error("hidden page command started the engine");
   a_req_pulse: assert property ((ce && fl_req[0]) |=> !fl_req[0])
      else $error("engine request longer than one cycle");
   a_req_cause: assert property ($rose(fl_req[0]) |-> con0_r)
      else $error("engine request without command write");
   a_erase_align: assert property ((fl_req[1] && fl_op[3:2] == 2'h2)
      |-> fl_addr[24:16] == 9'h000)
      else $error("page erase address not page aligned");
   a_boot_hold: assert property ((!$past(rst) && !$past(rst, 2))
      |-> $stable(serial_download))
      else $error("boot mode changed outside reset");
endmodule // fpl_top_chk

bind fpl_top fpl_top_chk #(.BANKS(BANKS)) i_chk (
   .clk_sys(clk_sys), .rst(rst), .ce(ce), .por(por), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .boot_select_pin_n(boot_select_pin_n), .serial_download(serial_download),
   .fl_req(fl_req), .fl_op(fl_op), .fl_addr(fl_addr), .fl_data(fl_data),
   .fl_done(fl_done), .fl_fail(fl_fail), .ext_req(ext_req), .ext_write(ext_write),
   .ext_bank(ext_bank), .ext_addr(ext_addr), .ext_grant(ext_grant), .ext_deny(ext_deny)
);

`default_nettype wire

// [tb/test_flash_protection_logic.sv]
// Self-checking bench for the flash protection top
`timescale 1ns/10ps
`default_nettype none

module test_flash_protection_logic;
   typedef struct packed {
      logic [31:0] h0;
      logic [31:0] h1;
      logic w;
      logic b;
      logic [15:0] a;
      logic g;
   } fpl_row_t;
   localparam logic [31:0] FULL = 32'hffffffff;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic por = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata;
   logic [31:0] rv;
   logic pin_n = 1'b0;
   logic serial_download;
   logic [1:0] fl_req;
   logic [1:0] fl_done = 2'h0;
   logic [1:0] fl_fail = 2'h0;
   logic [1:0] fail_mask = 2'h0;
   logic [3:0] fl_op;
   logic [31:0] fl_addr;
   logic [15:0] fl_data;
   logic ext_req = 1'b0;
   logic ext_write = 1'b0;
   logic ext_bank = 1'b0;
   logic [15:0] ext_addr = 16'h0;
   logic ext_grant;
   logic ext_deny;
   int n_mismatch = 0;
   int comparisons = 0;
   int n_req = 0;
   fpl_row_t rows[10] = '{
      '{FULL, FULL, 1'b1, 1'b0, 16'h0800, 1'b1},
      '{32'hfffffffd, FULL, 1'b1, 1'b0, 16'h0800, 1'b0},
      '{32'hfffffffd, FULL, 1'b1, 1'b0, 16'h1000, 1'b1},
      '{32'hfffffffd, FULL, 1'b0, 1'b0, 16'h0800, 1'b1},
      '{32'h7fffffff, FULL, 1'b0, 1'b0, 16'h0000, 1'b0},
      '{32'h7fffffff, FULL, 1'b0, 1'b1, 16'h0000, 1'b0},
      '{FULL, FULL, 1'b0, 1'b0, 16'hf800, 1'b0},
      '{FULL, FULL, 1'b1, 1'b0, 16'hf7ff, 1'b1},
      '{FULL, 32'h7fffffff, 1'b1, 1'b1, 16'hf800, 1'b0},
      '{FULL, 32'h7fffffff, 1'b0, 1'b1, 16'hf800, 1'b1}
   };
   logic [7:0] ra[6] = '{8'h20, 8'ha0, 8'h04, 8'h84, 8'h1c, 8'h14};
   logic [31:0] rx[6] = '{FULL, FULL, 32'h80, 32'h80, 32'h0, 32'h0};

   always #2 clk_sys = ~clk_sys;

   fpl_top i_dut (
      .clk_sys(clk_sys), .rst(rst), .ce(ce), .por(por), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .boot_select_pin_n(pin_n), .serial_download(serial_download), .fl_req(fl_req),
      .fl_op(fl_op), .fl_addr(fl_addr), .fl_data(fl_data), .fl_done(fl_done),
      .fl_fail(fl_fail), .ext_req(ext_req), .ext_write(ext_write), .ext_bank(ext_bank),
      .ext_addr(ext_addr), .ext_grant(ext_grant), .ext_deny(ext_deny)
   );

   // Engine finishes one cycle after each request
   always @(posedge clk_sys) begin
      fl_done <= fl_req;
      fl_fail <= fl_req & fail_mask;
      if (fl_req != 2'h0) begin
         n_req <= n_req + 1;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic do_reset(input logic p, input logic pin);
      @(posedge clk_sys);
      rst <= 1'b1;
      por <= p;
      pin_n <= pin;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      por <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      rv = reg_rdata;
   endtask

   task automatic ext(input logic w, input logic b, input logic [15:0] a, input logic g);
      @(posedge clk_sys);
      ext_req <= 1'b1;
      ext_write <= w;
      ext_bank <= b;
      ext_addr <= a;
      @(posedge clk_sys);
      ext_req <= 1'b0;
      #1;
      chk({ext_grant, ext_deny}, {g, ~g});
   endtask

   // Issue a command and poll status until done or failed
   task automatic cmd(input logic [7:0] base, input logic [7:0] c, input logic ok, input int nr);
      int i;
      int r0;
      r0 = n_req;
      wr(base + 8'h08, {24'h0, c});
      rv = 32'h0;
      for (i = 0; i < 12 && rv[1:0] == 2'h0; i++) begin
         rd(base);
      end
      chk(rv & 32'h2, ok ? 32'h0 : 32'h2);
      chk(n_req - r0, nr);
   endtask

   task automatic save(input logic [31:0] p, input logic [31:0] key, input logic ok);
      wr(8'h1c, p);
      wr(8'h04, 32'h40);
      wr(8'h10, {16'h0, key[31:16]});
      wr(8'h0c, {16'h0, key[15:0]});
      cmd(8'h00, 8'h0c, ok, 0);
   endtask

   task automatic merase(input logic [15:0] d, input logic ok);
      wr(8'h0c, {16'h0, d});
      wr(8'h10, 32'hffc3);
      wr(8'h04, 32'h88);
      cmd(8'h00, 8'h06, ok, ok);
   endtask

   // Watchdog, far beyond the expected run length
   initial begin
      #40000;
      n_mismatch++;
      stop_test();
   end

   initial begin
      do_reset(1'b1, 1'b0);
      repeat (3) @(posedge clk_sys);
      #1;
      chk(serial_download, 32'h1);
      foreach (rows[k]) begin
         wr(8'h20, rows[k].h0);
         wr(8'ha0, rows[k].h1);
         rd(8'h20);
         chk(rv, rows[k].h0);
         ext(rows[k].w, rows[k].b, rows[k].a, rows[k].g);
      end
      wr(8'h14, 32'h5a5a5a5a);
      do_reset(1'b0, 1'b1);
      foreach (ra[k]) begin
         rd(ra[k]);
         chk(rv, rx[k]);
      end
      // Writes while disabled are dropped
      @(posedge clk_sys);
      ce <= 1'b0;
      wr(8'h20, 32'h0);
      @(posedge clk_sys);
      ce <= 1'b1;
      rd(8'h20);
      chk(rv, FULL);
      chk(serial_download, 32'h0);
      wr(8'h10, 32'h1000);
      wr(8'h0c, 32'h5a);
      cmd(8'h00, 8'h02, 1'b1, 1);
      chk({fl_op[1:0], fl_addr[15:0], fl_data[7:0]}, {2'h1, 16'h1000, 8'h5a});
      rd(8'h00);
      chk(rv & 32'hb, 32'h0);
      // Busy while the engine works, then done with pending
      wr(8'h04, 32'h10);
      wr(8'h08, 32'h02);
      rd(8'h00);
      chk(rv, 32'h4);
      rd(8'h00);
      chk(rv, 32'h9);
      wr(8'h00, 32'h2);
      rd(8'h00);
      chk(rv, 32'h2);
      rd(8'h00);
      chk(rv, 32'h0);
      fail_mask = 2'h1;
      cmd(8'h00, 8'h02, 1'b0, 1);
      fail_mask = 2'h0;
      wr(8'h20, 32'hfffffffd);
      wr(8'h10, 32'h0800);
      cmd(8'h00, 8'h02, 1'b0, 0);
      wr(8'h10, 32'hf800);
      cmd(8'h00, 8'h05, 1'b0, 0);
      wr(8'ha0, 32'h7fffffff);
      wr(8'h90, 32'hf800);
      cmd(8'h80, 8'h02, 1'b0, 0);
      wr(8'ha0, FULL);
      wr(8'h90, 32'hfa00);
      cmd(8'h80, 8'h05, 1'b1, 1);
      chk({fl_op[3:2], fl_addr[31:16]}, {2'h2, 16'hfa00});
      save(32'hfffffffb, 32'h12345678, 1'b1);
      ext(1'b1, 1'b0, 16'h1000, 1'b1);
      do_reset(1'b0, 1'b1);
      ext(1'b1, 1'b0, 16'h1000, 1'b0);
      save(FULL, 32'h0, 1'b0);
      merase(16'h3cfe, 1'b0);
      save(32'hfffffffb, 32'hdeaddead, 1'b0);
      merase(16'h3cff, 1'b1);
      chk(fl_op[1:0], 32'h3);
      do_reset(1'b0, 1'b1);
      ext(1'b1, 1'b0, 16'h1000, 1'b1);
      save(32'hfffffffb, 32'hdeaddead, 1'b1);
      do_reset(1'b0, 1'b1);
      ext(1'b1, 1'b0, 16'h1000, 1'b0);
      save(FULL, 32'hdeaddead, 1'b0);
      stop_test();
   end
endmodule // test_flash_protection_logic

`default_nettype wire
